// *** hdl/flash_request_checker.sv ***
// parameter checks on a latched update request
`timescale 1ns/1ps
module flash_request_checker (
	input wire logic [1:0] op,
	input wire logic [15:0] addr,
	input wire logic [7:0] count,
	input wire logic [7:0] operand,
	input wire logic prot_pflash,
	input wire logic prot_dflash,
	output logic ok
);
	logic is_d;
	logic in_map;
	logic prot;
	logic [7:0] row;
	logic [7:0] offs;
	logic end_ok;

	// ****************************************
	// decode and range checks
	// ****************************************
	// target array picked from the address alone
	always_comb begin
		is_d = flash_update_pkg::addr_is_dflash(addr);
		in_map = is_d || (addr <= flash_update_pkg::PF_LAST);
		prot = is_d ? prot_dflash : prot_pflash;
		row = is_d ? flash_update_pkg::DF_ROW : flash_update_pkg::PF_ROW;
		offs = addr[7:0] & (row - 8'h01);
		end_ok = ({1'b0, offs} + {1'b0, count}) <= {1'b0, row};
		case (op)
			flash_update_pkg::OP_PROGRAM: begin
				// odd start or odd count only matters on the program array
				ok = in_map && !prot && (count != 8'h00) && (count <= row) && end_ok
					&& (is_d || (!addr[0] && !count[0]));
			end
			flash_update_pkg::OP_ERASE: begin
				ok = in_map && !prot && (operand <= 8'h01);
			end
			flash_update_pkg::OP_INFO: begin
				ok = (operand == 8'h00);
			end
			default: begin
				ok = 1'b0;
			end
		endcase
	end

endmodule : flash_request_checker

// *** hdl/flash_timer.sv ***
// flash timer: 7-bit counter with optional 12-bit prescaler
`timescale 1ns/1ps
module flash_timer (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic erase_mode,
	input wire logic [6:0] overflow_value,
	output logic overflow
);
	typedef struct packed {
		logic [11:0] pre;
		logic [6:0] cnt;
		logic ovf;
	} timer_t;

	timer_t t_reg;
	timer_t t_next;

	// ****************************************
	// counting
	// ****************************************
	// disabled timer holds both counters at zero
	always_comb begin
		logic step;
		step = 1'b0;
		t_next = t_reg;
		t_next.ovf = 1'b0;
		if (!enable) begin
			t_next.pre = 12'h000;
			t_next.cnt = 7'h00;
		end else begin
			step = erase_mode ? (t_reg.pre == 12'hfff) : 1'b1;
			t_next.pre = erase_mode ? t_reg.pre + 12'h001 : 12'h000;
			if (t_reg.cnt == overflow_value) begin
				t_next.ovf = 1'b1;
				t_next.cnt = 7'h00;
			end else if (step) begin
				t_next.cnt = t_reg.cnt + 7'h01;
			end
		end
	end

	// state register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			t_reg <= '0;
		end else begin
			t_reg <= t_next;
		end
	end

	assign overflow = t_reg.ovf;

endmodule : flash_timer

// *** hdl/flash_update_control.sv ***
// flash update control: registers, request checks and timed sequences
`timescale 1ns/1ps
module flash_update_control #(
	parameter int ERASE_CYCLES = flash_update_pkg::T_ERASE_CYC,
	parameter int MASS_CYCLES = flash_update_pkg::T_ME_CYC,
	parameter logic [31:0] CHIP_ID = 32'h5a5a_0001 // arbitrary value
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic req_start,
	input wire logic [1:0] req_op,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_src,
	input wire logic [7:0] req_count,
	input wire logic [7:0] req_operand,
	output logic busy,
	output logic req_done,
	output logic failure_carry,
	output logic xram_rd,
	output logic [15:0] xram_addr,
	input wire logic [7:0] xram_rdata,
	output logic flash_wr,
	output logic [15:0] flash_addr,
	output logic [7:0] flash_wdata,
	output logic iram_wr,
	output logic [7:0] iram_addr,
	output logic [7:0] iram_wdata,
	output logic [7:0] pflash_ctl,
	output logic [7:0] dflash_ctl,
	output logic timer_enable,
	output logic timer_overflow,
	input wire logic ecc_single,
	input wire logic ecc_double,
	input wire logic ecc_dflash,
	input wire logic [15:0] ecc_addr,
	input wire logic prot_pflash,
	input wire logic prot_dflash
);
	// ****************************************
	// types and state
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CHECK = 4'h1,
		ST_INIT = 4'h3,
		ST_SETUP = 4'h2,
		ST_HV = 4'h6,
		ST_FETCH = 4'h7,
		ST_LOAD = 4'h5,
		ST_WRITE = 4'h4,
		ST_ENDOP = 4'hc,
		ST_RECOVER = 4'hd,
		ST_DONE = 4'hf,
		ST_INFO = 4'he
	} state_t;

	typedef struct packed {
		state_t state;
		logic [7:0] pfc;
		logic [7:0] dfc;
		logic [7:0] sts;
		logic [7:0] eal;
		logic [7:0] eah;
		logic [7:0] ftv;
		logic abort;
		logic [22:0] wait_cnt;
		logic [6:0] idx;
		logic tgt_d;
		logic [1:0] op;
		logic [15:0] addr;
		logic [15:0] src;
		logic [7:0] cnt;
		logic [7:0] operand;
		logic carry;
		logic done;
		logic busy;
		logic col_pulse;
		logic [7:0] rdata;
		logic xram_rd;
		logic [15:0] xaddr;
		logic flash_wr;
		logic [15:0] faddr;
		logic [7:0] fdata;
		logic iram_wr;
		logic [7:0] iaddr;
		logic [7:0] idata;
		logic [1:0] prot_s1;
		logic [1:0] prot_s2;
	} regs_t;

	localparam regs_t R_RST = '{
		state: ST_IDLE,
		pfc: flash_update_pkg::RST_CTL,
		dfc: flash_update_pkg::RST_CTL,
		sts: flash_update_pkg::RST_STS,
		eal: flash_update_pkg::RST_ERR_ADDR,
		eah: flash_update_pkg::RST_ERR_ADDR,
		ftv: flash_update_pkg::RST_FTV,
		default: '0
	};

	regs_t r_reg;
	regs_t r_next;
	logic chk_ok;

	// software view of a control write: column enable may only be cleared
	function automatic logic [7:0] sw_ctl(input logic [7:0] cur, input logic [7:0] w);
		logic [7:0] v;
		v = cur;
		v[3:0] = w[3:0];
		v[flash_update_pkg::BIT_COL] = cur[flash_update_pkg::BIT_COL] & w[flash_update_pkg::BIT_COL];
		return v;
	endfunction : sw_ctl

	// ****************************************
	// next-state logic
	// ****************************************
	// software writes first, then hardware updates, so hardware sets win
	always_comb begin
		logic [7:0] ctl;
		logic tick;
		logic finish;
		logic mass;
		ctl = 8'h00;
		finish = 1'b0;
		r_next = r_reg;
		tick = (r_reg.wait_cnt == 23'h00_0000);
		mass = r_reg.operand[0];
		r_next.done = 1'b0;
		r_next.xram_rd = 1'b0;
		r_next.flash_wr = 1'b0;
		r_next.iram_wr = 1'b0;
		r_next.col_pulse = 1'b0;
		r_next.prot_s1 = {prot_dflash, prot_pflash};
		r_next.prot_s2 = r_reg.prot_s1;
		if (!tick) begin
			r_next.wait_cnt = r_reg.wait_cnt - 23'h00_0001;
		end
		// register writes; read-only fields fall through untouched
		if (sfr_wr) begin
			case (sfr_addr)
				flash_update_pkg::ADDR_PFC: r_next.pfc = sw_ctl(r_reg.pfc, sfr_wdata);
				flash_update_pkg::ADDR_DFC: r_next.dfc = sw_ctl(r_reg.dfc, sfr_wdata);
				flash_update_pkg::ADDR_STS: begin
					r_next.sts[6:5] = sfr_wdata[6:5];
					r_next.sts[3:0] = r_reg.sts[3:0] & sfr_wdata[3:0];
				end
				flash_update_pkg::ADDR_FTV: r_next.ftv = sfr_wdata;
				default: begin
				end
			endcase
		end
		// error flags and address, set beats a same-cycle clear
		if (ecc_single || ecc_double) begin
			r_next.sts[0] = r_next.sts[0] | (ecc_single & ~ecc_dflash);
			r_next.sts[1] = r_next.sts[1] | (ecc_double & ~ecc_dflash);
			r_next.sts[2] = r_next.sts[2] | (ecc_single & ecc_dflash);
			r_next.sts[3] = r_next.sts[3] | (ecc_double & ecc_dflash);
			r_next.eal = ecc_addr[7:0];
			r_next.eah = ecc_addr[15:8];
		end
		// timer enable follows a hardware column enable by one cycle
		if (r_reg.col_pulse) begin
			r_next.sts[flash_update_pkg::STS_TMR_EN] = 1'b1;
		end
		ctl = r_next.tgt_d ? r_next.dfc : r_next.pfc;
		// request sequencer
		case (r_reg.state)
			ST_IDLE: begin
				if (req_start) begin
					r_next.op = req_op;
					r_next.addr = req_addr;
					r_next.src = req_src;
					r_next.cnt = req_count;
					r_next.operand = req_operand;
					r_next.tgt_d = flash_update_pkg::addr_is_dflash(req_addr);
					r_next.idx = 7'h00;
					r_next.carry = 1'b0;
					r_next.busy = 1'b1;
					r_next.state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (r_reg.op == flash_update_pkg::OP_INFO) begin
					r_next.carry = !chk_ok;
					r_next.state = ST_INFO;
				end else if (!chk_ok || (r_reg.tgt_d && r_reg.abort)) begin
					r_next.carry = 1'b1;
					r_next.state = ST_DONE;
				end else begin
					r_next.state = ST_INIT;
				end
			end
			ST_INIT: begin
				// timer set up before any timed step
				r_next.ftv = (r_reg.op == flash_update_pkg::OP_ERASE) ?
					flash_update_pkg::FTV_ERASE : flash_update_pkg::FTV_PROG;
				ctl[flash_update_pkg::BIT_PROG] = (r_reg.op == flash_update_pkg::OP_PROGRAM);
				ctl[flash_update_pkg::BIT_ERASE] = (r_reg.op == flash_update_pkg::OP_ERASE);
				ctl[flash_update_pkg::BIT_MAS] = (r_reg.op == flash_update_pkg::OP_ERASE) && mass;
				r_next.wait_cnt = flash_update_pkg::wait_load(flash_update_pkg::T_VNS_CYC);
				r_next.state = ST_SETUP;
			end
			ST_SETUP: begin
				if (tick) begin
					ctl[flash_update_pkg::BIT_PUMP] = 1'b1;
					if (r_reg.op == flash_update_pkg::OP_PROGRAM) begin
						r_next.wait_cnt = flash_update_pkg::wait_load(flash_update_pkg::T_PGS_CYC);
					end else begin
						r_next.wait_cnt = flash_update_pkg::wait_load(mass ? MASS_CYCLES : ERASE_CYCLES);
					end
					r_next.state = ST_HV;
				end
			end
			ST_HV: begin
				if (r_reg.tgt_d && r_reg.abort) begin
					finish = 1'b1;
				end else if (tick) begin
					finish = (r_reg.op != flash_update_pkg::OP_PROGRAM);
					r_next.state = ST_FETCH;
				end
			end
			ST_FETCH: begin
				r_next.xram_rd = 1'b1;
				r_next.xaddr = r_reg.src + {9'h000, r_reg.idx};
				r_next.state = ST_LOAD;
			end
			ST_LOAD: begin
				// byte goes out with hardware column enable
				r_next.fdata = xram_rdata;
				r_next.faddr = r_reg.addr + {9'h000, r_reg.idx};
				r_next.flash_wr = 1'b1;
				ctl[flash_update_pkg::BIT_COL] = 1'b1;
				r_next.col_pulse = 1'b1;
				r_next.wait_cnt = flash_update_pkg::wait_load(flash_update_pkg::T_PROG_CYC);
				r_next.state = ST_WRITE;
			end
			ST_WRITE: begin
				if (tick || (r_reg.tgt_d && r_reg.abort)) begin
					ctl[flash_update_pkg::BIT_COL] = 1'b0;
					r_next.sts[flash_update_pkg::STS_TMR_EN] = 1'b0;
					r_next.idx = r_reg.idx + 7'h01;
					// abort only ever stops a data array operation
					finish = (({1'b0, r_reg.idx} + 8'h01) == r_reg.cnt) || (r_reg.tgt_d && r_reg.abort);
					r_next.state = ST_FETCH;
				end
			end
			ST_ENDOP: begin
				if (tick) begin
					ctl[flash_update_pkg::BIT_PUMP] = 1'b0;
					ctl[flash_update_pkg::BIT_MAS] = 1'b0;
					r_next.wait_cnt = flash_update_pkg::wait_load(flash_update_pkg::T_RCV_CYC);
					r_next.state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (tick) begin
					r_next.state = ST_DONE;
				end
			end
			ST_INFO: begin
				// invalid selector fills the buffer with zeros
				r_next.iram_wr = 1'b1;
				r_next.iaddr = r_reg.cnt + {6'h00, r_reg.idx[1:0]};
				r_next.idata = r_reg.carry ? 8'h00 : CHIP_ID[31 - 8 * r_reg.idx[1:0] -: 8];
				r_next.idx = r_reg.idx + 7'h01;
				if (r_reg.idx[1:0] == 2'h3) begin
					r_next.state = ST_DONE;
				end
			end
			ST_DONE: begin
				r_next.done = 1'b1;
				r_next.busy = 1'b0;
				r_next.state = ST_IDLE;
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase
		// closing a program or erase: drop select, hold pump for T_NVH_CYC (T_NVHL_CYC on mass erase)
		if (finish) begin
			ctl[flash_update_pkg::BIT_PROG] = 1'b0;
			ctl[flash_update_pkg::BIT_ERASE] = 1'b0;
			r_next.wait_cnt = flash_update_pkg::wait_load(mass && r_reg.op == flash_update_pkg::OP_ERASE ?
				flash_update_pkg::T_NVHL_CYC : flash_update_pkg::T_NVH_CYC);
			r_next.state = ST_ENDOP;
		end
		if (r_reg.busy) begin
			if (r_reg.tgt_d) begin
				r_next.dfc = ctl;
			end else begin
				r_next.pfc = ctl;
			end
		end
		// abort clears with the data pump; a same-cycle software set wins
		if (r_reg.dfc[flash_update_pkg::BIT_PUMP] && !r_next.dfc[flash_update_pkg::BIT_PUMP]) begin
			r_next.abort = 1'b0;
		end
		if (sfr_wr && sfr_addr == flash_update_pkg::ADDR_ABT && sfr_wdata[0]) begin
			r_next.abort = 1'b1;
		end
		// busy and fixed bits are hardware owned
		r_next.pfc[flash_update_pkg::BIT_BUSY] = (r_next.busy & ~r_next.tgt_d) | r_next.pfc[3];
		r_next.dfc[flash_update_pkg::BIT_BUSY] = (r_next.busy & r_next.tgt_d) | r_next.dfc[3];
		r_next.pfc[flash_update_pkg::BIT_ONE] = 1'b1;
		r_next.dfc[flash_update_pkg::BIT_ONE] = 1'b1;
		r_next.pfc[flash_update_pkg::BIT_ZERO] = 1'b0;
		r_next.dfc[flash_update_pkg::BIT_ZERO] = 1'b0;
		r_next.sts[7] = 1'b1;
		r_next.sts[4] = 1'b0;
		// registered read data, unmapped offsets read zero
		r_next.rdata = 8'h00;
		if (sfr_rd) begin
			case (sfr_addr)
				flash_update_pkg::ADDR_PFC: r_next.rdata = r_reg.pfc;
				flash_update_pkg::ADDR_DFC: r_next.rdata = r_reg.dfc;
				flash_update_pkg::ADDR_STS: r_next.rdata = r_reg.sts;
				flash_update_pkg::ADDR_EAL: r_next.rdata = r_reg.eal;
				flash_update_pkg::ADDR_EAH: r_next.rdata = r_reg.eah;
				flash_update_pkg::ADDR_FTV: r_next.rdata = r_reg.ftv;
				flash_update_pkg::ADDR_ABT: r_next.rdata = {7'h00, r_reg.abort};
				default: r_next.rdata = 8'h00;
			endcase
		end
	end

	// state register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			r_reg <= R_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// submodules and outputs
	// ****************************************
	flash_request_checker u_check (
		.op(r_reg.op),
		.addr(r_reg.addr),
		.count(r_reg.cnt),
		.operand(r_reg.operand),
		.prot_pflash(r_reg.prot_s2[0]),
		.prot_dflash(r_reg.prot_s2[1]),
		.ok(chk_ok)
	);

	flash_timer u_timer (
		.clock(clock),
		.arst_n(arst_n),
		.enable(r_reg.sts[flash_update_pkg::STS_TMR_EN]),
		.erase_mode(r_reg.ftv[7]),
		.overflow_value(r_reg.ftv[6:0]),
		.overflow(timer_overflow)
	);

	assign sfr_rdata = r_reg.rdata;
	assign busy = r_reg.busy;
	assign req_done = r_reg.done;
	assign failure_carry = r_reg.carry;
	assign xram_rd = r_reg.xram_rd;
	assign xram_addr = r_reg.xaddr;
	assign flash_wr = r_reg.flash_wr;
	assign flash_addr = r_reg.faddr;
	assign flash_wdata = r_reg.fdata;
	assign iram_wr = r_reg.iram_wr;
	assign iram_addr = r_reg.iaddr;
	assign iram_wdata = r_reg.idata;
	assign pflash_ctl = r_reg.pfc;
	assign dflash_ctl = r_reg.dfc;
	assign timer_enable = r_reg.sts[flash_update_pkg::STS_TMR_EN];

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	a_timer_follows: assert property ((r_reg.state == ST_LOAD) |=> ##1 timer_enable)
		else $error("timer enable did not follow column enable");
	a_refuse_carry: assert property ((r_reg.state == ST_CHECK && !chk_ok && r_reg.op != 2'h2)
		|=> ##1 (req_done && failure_carry))
		else $error("refused request did not end with carry");
	a_busy_bit: assert property ((busy && !r_reg.tgt_d) |-> pflash_ctl[6])
		else $error("program array busy bit low during request");
	a_done_release: assert property ($fell(busy) |-> req_done && !pflash_ctl[3] && !dflash_ctl[3])
		else $error("request released before pump off");
	a_mass_select: assert property ((r_reg.state == ST_HV && r_reg.op == 2'h1)
		|-> ((r_reg.tgt_d ? dflash_ctl[2] : pflash_ctl[2]) == r_reg.operand[0]))
		else $error("mass select does not match erase type");
	a_info_msb: assert property ((iram_wr && iram_addr == r_reg.cnt && !failure_carry)
		|-> iram_wdata == CHIP_ID[31:24])
		else $error("identity msb not first");
	a_err_capture: assert property ((ecc_single || ecc_double) |=> {r_reg.eah, r_reg.eal} == $past(ecc_addr))
		else $error("error address not captured");
	a_col_sw_hold: assert property ((sfr_wr && sfr_addr == 8'hd1 && !busy && !pflash_ctl[5])
		|=> !pflash_ctl[5])
		else $error("software set column enable");
	a_byte_bound: assert property (flash_wr |-> r_reg.idx < (r_reg.tgt_d ? 7'd32 : 7'd64))
		else $error("byte index beyond wordline");
	a_reserved_read: assert property ((sfr_rd && sfr_addr == 8'hd2) |=> sfr_rdata[4] && !sfr_rdata[7])
		else $error("reserved bits read wrong");

endmodule : flash_update_control

// *** include/flash_update_pkg.sv ***
// constants, map and helpers shared by the flash update control files
package flash_update_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_PFC = 8'hd1;
	localparam logic [7:0] ADDR_DFC = 8'hd2;
	localparam logic [7:0] ADDR_STS = 8'hd3;
	localparam logic [7:0] ADDR_EAL = 8'hd4;
	localparam logic [7:0] ADDR_EAH = 8'hd5;
	localparam logic [7:0] ADDR_FTV = 8'hd6;
	localparam logic [7:0] ADDR_ABT = 8'hdd;

	// ****************************************
	// reset values and field positions
	// ****************************************
	localparam logic [7:0] RST_CTL = 8'h10;
	localparam logic [7:0] RST_STS = 8'h80;
	localparam logic [7:0] RST_ERR_ADDR = 8'h00;
	localparam logic [7:0] RST_FTV = 8'h78;
	localparam int BIT_PROG = 0;
	localparam int BIT_ERASE = 1;
	localparam int BIT_MAS = 2;
	localparam int BIT_PUMP = 3;
	localparam int BIT_ONE = 4;
	localparam int BIT_COL = 5;
	localparam int BIT_BUSY = 6;
	localparam int BIT_ZERO = 7;
	localparam int STS_TMR_EN = 5;
	localparam int STS_SBE_IE = 6;
	// timer setting loaded by the request init step: mode bit over overflow value
	localparam logic [7:0] FTV_PROG = 8'h78;
	localparam logic [7:0] FTV_ERASE = 8'hf8;

	// ****************************************
	// address map and wordline sizes
	// ****************************************
	localparam logic [15:0] PF_LAST = 16'h7fff;
	localparam logic [15:0] DF_FIRST = 16'ha000;
	localparam logic [15:0] DF_LAST = 16'hafff;
	localparam logic [7:0] PF_ROW = 8'h40;
	localparam logic [7:0] DF_ROW = 8'h20;

	typedef enum logic [1:0] {
		OP_PROGRAM = 2'h0,
		OP_ERASE = 2'h1,
		OP_INFO = 2'h2
	} op_t;

	// ****************************************
	// timing, 25 MHz clock
	// ****************************************
	localparam int CLK_NS = 40;
	localparam int T_VNS_NS = 5000;
	localparam int T_PGS_NS = 10000;
	localparam int T_PROG_NS = 20000;
	localparam int T_NVH_NS = 5000;
	localparam int T_NVHL_NS = 100000;
	localparam int T_RCV_NS = 1000;
	localparam int T_ERASE_NS = 20000000;
	localparam int T_ME_NS = 200000000;
	localparam int T_VNS_CYC = (T_VNS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_PGS_CYC = (T_PGS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_PROG_CYC = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_NVH_CYC = (T_NVH_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_NVHL_CYC = (T_NVHL_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RCV_CYC = (T_RCV_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ME_CYC = (T_ME_NS + CLK_NS - 1) / CLK_NS;

	// data flash window decode, shared by checker and sequencer
	function automatic logic addr_is_dflash(input logic [15:0] a);
		return (a >= DF_FIRST) && (a <= DF_LAST);
	endfunction : addr_is_dflash

	// wait counter preload for a cycle count
	function automatic logic [22:0] wait_load(input int c);
		return 23'(c - 1);
	endfunction : wait_load

endpackage : flash_update_pkg

// *** verification/tb.sv ***
// self-checking bench for the flash update control block
`timescale 1ns/1ps
module tb;
	// ****************************************
	// signals and design
	// ****************************************
	localparam logic [31:0] chip_id_val = 32'h1357_9bdf; // arbitrary value
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, req_start = 1'b0, ecc_single = 1'b0, ecc_dflash = 1'b0;
	logic prot_pflash = 1'b0, prot_dflash = 1'b0, ecc_double = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, req_count = 8'h00, req_operand = 8'h00;
	logic [15:0] req_addr = 16'h0000, req_src = 16'h0000, ecc_addr = 16'h0000;
	logic [7:0] sfr_rdata, xram_rdata, iram_addr, iram_wdata, flash_wdata, pflash_ctl, dflash_ctl;
	logic busy, req_done, failure_carry, xram_rd, flash_wr, iram_wr, timer_enable, timer_overflow;
	logic [15:0] xram_addr, flash_addr, last_fa;
	logic [7:0] last_fd;
	logic [7:0] seen_p = 8'h00, seen_d = 8'h00;
	logic [7:0] iram_mem [256];
	logic [1:0] col_q = 2'b00;
	int error_cnt = 0, checks = 0, wr_cnt = 0, cyc = 0, xr_cnt = 0, ov_cnt = 0;

	flash_update_control #(.ERASE_CYCLES(50), .MASS_CYCLES(80), .CHIP_ID(chip_id_val)) dut_u (
		.clock, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .req_start,
		.req_op, .req_addr, .req_src, .req_count, .req_operand, .busy, .req_done, .failure_carry,
		.xram_rd, .xram_addr, .xram_rdata, .flash_wr, .flash_addr, .flash_wdata, .iram_wr,
		.iram_addr, .iram_wdata, .pflash_ctl, .dflash_ctl, .timer_enable, .timer_overflow,
		.ecc_single, .ecc_double, .ecc_dflash, .ecc_addr, .prot_pflash, .prot_dflash);

	// source memory answers in the same cycle, so its pattern is a plain function of address
	assign xram_rdata = xram_addr[7:0] ^ 8'h5a;

	// clock at 25 MHz
	initial begin
		forever #20 clock = ~clock;
	end

	// hang guard, far above the longest run of the sequence below
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			summarize();
		end
	end

	// watch array writes, control bits and identity bytes
	always @(negedge clock) begin
		seen_p = seen_p | pflash_ctl;
		seen_d = seen_d | dflash_ctl;
		if (col_q == 2'b01) chk("timer_enable", 16'(timer_enable), 16'h0001);
		col_q = {col_q[0], pflash_ctl[5] | dflash_ctl[5]};
		if (flash_wr === 1'b1) begin
			wr_cnt++;
			last_fa = flash_addr;
			last_fd = flash_wdata;
			chk("busy_bit", 16'(flash_addr[15] ? dflash_ctl[6] : pflash_ctl[6]), 16'h0001);
		end
		if (iram_wr === 1'b1) iram_mem[iram_addr] = iram_wdata;
		if (xram_rd === 1'b1) xr_cnt++;
		if (timer_overflow === 1'b1) ov_cnt++;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic summarize();
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic sfr_write(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clock);
		sfr_wr <= 1'b0;
	endtask : sfr_write

	// read data is registered, so it is looked at after the taking edge has landed
	task automatic rchk(logic [7:0] a, logic [7:0] exp);
		@(posedge clock);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clock);
		sfr_rd <= 1'b0;
		@(negedge clock);
		chk("sfr_rdata", 16'(sfr_rdata), 16'(exp));
	endtask : rchk

	task automatic run_req(logic [1:0] op, logic [15:0] a, logic [15:0] src, logic [7:0] cnt,
		logic [7:0] opd, logic exp_c, int lat);
		int n;
		n = 0;
		@(posedge clock);
		req_op <= op;
		req_addr <= a;
		req_src <= src;
		req_count <= cnt;
		req_operand <= opd;
		req_start <= 1'b1;
		@(posedge clock);
		req_start <= 1'b0;
		@(negedge clock);
		chk("busy", 16'(busy), 16'h0001);
		while (req_done !== 1'b1 && n < 8000) begin
			@(negedge clock);
			n++;
		end
		chk("req_done", 16'(req_done), 16'h0001);
		if (lat > 0) chk("done_cycles", 16'(n), 16'(lat));
		chk("failure_carry", 16'(failure_carry), 16'(exp_c));
		chk("busy_after", 16'(busy), 16'h0000);
	endtask : run_req

	// ****************************************
	// scenarios
	// ****************************************
	task automatic reset_values();
		logic [7:0] ra [7] = '{8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hdd, 8'hd0};
		logic [7:0] rv [7] = '{8'h10, 8'h10, 8'h80, 8'h00, 8'h78, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) rchk(ra[i], rv[i]);
	endtask : reset_values

	// read-only and reserved bits hold, bit 5 cannot be set by a write
	task automatic ctl_access();
		for (int j = 0; j < 2; j++) begin
			sfr_write(8'hd1 + 8'(j), 8'he7);
			rchk(8'hd1 + 8'(j), 8'h17);
			sfr_write(8'hd1 + 8'(j), 8'h08);
			rchk(8'hd1 + 8'(j), 8'h58);
			sfr_write(8'hd1 + 8'(j), 8'h00);
			rchk(8'hd1 + 8'(j), 8'h10);
		end
	endtask : ctl_access

	task automatic ecc_capture();
		@(posedge clock);
		ecc_addr <= 16'hbeef;
		ecc_single <= 1'b1;
		@(posedge clock);
		ecc_single <= 1'b0;
		rchk(8'hd4, 8'hef);
		rchk(8'hd5, 8'hbe);
	endtask : ecc_capture

	task automatic refused_reqs();
		logic [15:0] ad [10] = '{16'h0101, 16'h9000, 16'h003e, 16'ha01f, 16'h0100, 16'h0100,
			16'h0000, 16'ha000, 16'hb000, 16'h0000};
		logic [7:0] ct [10] = '{8'h02, 8'h02, 8'h04, 8'h02, 8'h00, 8'h03, 8'h42, 8'h21, 8'h00, 8'h00};
		int base;
		base = wr_cnt;
		for (int i = 0; i < 10; i++) run_req(i < 8 ? 2'h0 : 2'h1, ad[i], 16'h0000, ct[i], i == 9 ? 8'h02 : 8'h00, 1'b1, 2);
		@(posedge clock);
		prot_pflash <= 1'b1;
		repeat (4) @(posedge clock);
		run_req(2'h0, 16'h0100, 16'h0000, 8'h02, 8'h00, 1'b1, 2);
		@(posedge clock);
		prot_pflash <= 1'b0;
		repeat (4) @(posedge clock);
		chk("refused_writes", 16'(wr_cnt - base), 16'h0000);
	endtask : refused_reqs

	task automatic identity_req();
		for (int i = 0; i < 4; i++) iram_mem[8'h40 + i] = 8'hee;
		run_req(2'h2, 16'h0000, 16'h0000, 8'h40, 8'h00, 1'b0, 6);
		for (int i = 0; i < 4; i++) chk("id_byte", 16'(iram_mem[8'h40 + i]), 16'(chip_id_val[31 - 8 * i -: 8]));
		run_req(2'h2, 16'h0000, 16'h0000, 8'h40, 8'h01, 1'b1, 6);
		for (int i = 0; i < 4; i++) chk("id_clear", 16'(iram_mem[8'h40 + i]), 16'h0000);
	endtask : identity_req

	// a full timed request; the untouched array must keep its reset value
	task automatic valid_op(logic [1:0] op, logic [15:0] a, logic [15:0] src, logic [7:0] cnt,
		logic [7:0] opd, logic [3:0] bits);
		seen_p = 8'h00;
		seen_d = 8'h00;
		wr_cnt = 0;
		xr_cnt = 0;
		ov_cnt = 0;
		run_req(op, a, src, cnt, opd, 1'b0, 0);
		chk("ctl_bits", 16'(a[15] ? seen_d[3:0] : seen_p[3:0]), 16'(bits));
		chk("other_ctl", 16'(a[15] ? seen_p : seen_d), 16'h0010);
		chk("write_count", 16'(wr_cnt), op == 2'h0 ? 16'(cnt) : 16'h0000);
		chk("xram_reads", 16'(xr_cnt), op == 2'h0 ? 16'(cnt) : 16'h0000);
		chk("timer_ovf", 16'(ov_cnt != 0), 16'(op == 2'h0));
		if (op == 2'h0) chk("last_addr", last_fa, a + 16'(cnt) - 16'h0001);
		if (op == 2'h0) chk("last_data", 16'(last_fd), 16'(8'(src[7:0] + cnt - 8'h01) ^ 8'h5a));
	endtask : valid_op

	initial begin
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		reset_values();
		ctl_access();
		ecc_capture();
		refused_reqs();
		identity_req();
		valid_op(2'h0, 16'ha005, 16'h0030, 8'h01, 8'h00, 4'h9);
		valid_op(2'h0, 16'h0100, 16'h0010, 8'h02, 8'h00, 4'h9);
		rchk(8'hd6, 8'h78);
		valid_op(2'h1, 16'ha100, 16'h0000, 8'h00, 8'h00, 4'ha);
		rchk(8'hd6, 8'hf8);
		valid_op(2'h1, 16'ha100, 16'h0000, 8'h00, 8'h01, 4'he);
		summarize();
	end
endmodule : tb
